//--- src/hcrip_port.sv
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module hcrip_port (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [hcrip_pkg::ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [hcrip_pkg::DATA_W-1:0]   wb_dat_i,
  output logic      [hcrip_pkg::DATA_W-1:0]   wb_dat_o,
  output logic                                wb_ack_o,
  output logic                                irq,
  input  wire logic                           rx_packet_done,
  input  wire logic                           tx_packet_done,
  output logic                                mac_run,
  output logic      [1:0]                     loopback_mode,
  input  wire logic                           transmit_clock,
  output logic                                tx_domain_rst,
  output logic                                remote_transfer_request,
  output logic                                remote_transfer_request_oe,
  input  wire logic                           latch_write_ack,
  input  wire logic                           latch_read_ack,
  input  wire logic                           mem_ready,
  input  wire logic [hcrip_pkg::WORD_W-1:0]   latch_data_in,
  input  wire logic [hcrip_pkg::WORD_W-1:0]   mem_rdata,
  output logic      [hcrip_pkg::WORD_W-1:0]   mem_addr,
  output logic      [hcrip_pkg::WORD_W-1:0]   mem_wdata,
  output logic                                mem_write,
  output logic                                mem_read,
  output logic      [hcrip_pkg::WORD_W-1:0]   port_data,
  output logic                                port_write,
  input  wire logic                           idle_level_sel,
  input  wire logic                           tx_active,
  input  wire logic                           tx_enc_bit,
  output logic                                tx_pos,
  output logic                                tx_neg,
  input  wire logic                           line_encoder_decoder_isolate_test_n,
  output logic                                line_encoder_decoder_test_mode
);
  import hcrip_pkg::*;

  logic                rst_bus;      // synchronised bus-side reset
  logic [SY_W-1:0]     sy;           // synchronised pin lanes
  logic [2*WORD_W-1:0] data_s;       // synchronised data buses
  logic                latch_write_ack_prev_q;  // edge history of write ack
  logic                latch_read_ack_prev_q;  // edge history of read ack
  logic                tclk_prev_q;  // edge history of transmit clock
  logic                latch_write_ack_rise;
  logic                latch_read_ack_rise;
  logic                tclk_rise;

  // register bus
  logic       req;                   // new access, not yet answered
  logic       wr_en;
  logic [7:0] rdata;                 // read mux result

  // registers
  logic             cmd_stop_q;
  logic             cmd_start_q;
  logic [IRQ_W-1:0] isr_q;
  logic [IRQ_W-1:0] imr_q;
  logic [7:0]       dcr_q;
  logic [7:0]       tcr_q;
  logic             dcr_set_q;       // data config has been written
  logic [WORD_W-1:0] rsar_q;
  logic [WORD_W-1:0] rbcr_q;

  // remote transfer engine
  hcrip_rmt_e        state_q;
  logic              dir_wr_q;       // 1 write to memory, 0 read
  logic [WORD_W-1:0] cnt_q;          // bytes still to move
  logic              rdma_evt_q;     // one-cycle completion event
  logic [WORD_W-1:0] step;           // byte or word stride
  logic              launch_rd;
  logic              launch_wr;

  logic [2:0]        tx_edges_q;     // transmit clock edges seen
  logic [IRQ_W-1:0]  isr_set;
  logic [IRQ_W-1:0]  isr_clr;

  // reset asserts at once, releases on the bus clock
  hcrip_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clock (clock),
    .rst   (rst),
    .d     (1'b0),
    .q     (rst_bus)
  );

  // ack, ready, clock, select and isolate pins pass two flops before use
  hcrip_sync #(.W(SY_W), .RST_VAL(SY_RST)) u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({line_encoder_decoder_isolate_test_n, idle_level_sel, latch_read_ack,
             latch_write_ack, mem_ready, transmit_clock}),
    .q     (sy)
  );

  // data buses too; the strobes above qualify them
  hcrip_sync #(.W(2*WORD_W), .RST_VAL('0)) u_dat_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({mem_rdata, latch_data_in}),
    .q     (data_s)
  );

  // edge history on the second synchroniser stage only
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      latch_write_ack_prev_q <= 1'b0;
      latch_read_ack_prev_q <= 1'b0;
      tclk_prev_q <= 1'b0;
    end else begin
      latch_write_ack_prev_q <= sy[SY_LATCH_WRITE_ACK];
      latch_read_ack_prev_q <= sy[SY_LATCH_READ_ACK];
      tclk_prev_q <= sy[SY_TCLK];
    end
  end

  assign latch_write_ack_rise = sy[SY_LATCH_WRITE_ACK] & ~latch_write_ack_prev_q;
  assign latch_read_ack_rise = sy[SY_LATCH_READ_ACK] & ~latch_read_ack_prev_q;
  assign tclk_rise = sy[SY_TCLK] & ~tclk_prev_q;

  // transmit side leaves reset after two sampled clock edges
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      tx_domain_rst <= 1'b1;
      tx_edges_q    <= 3'h0;
    end else if (tx_domain_rst && tclk_rise) begin
      tx_edges_q <= tx_edges_q + 3'h1;
      if (tx_edges_q + 3'h1 >= TX_RST_EDGES) begin
        tx_domain_rst <= 1'b0;
      end
    end
  end

  // wishbone: one answer per access, dropped the cycle after
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = req & wb_we_i & wb_sel_i[0];

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata = 8'h00;
    unique case (wb_adr_i)
      CMD_OFS: begin
        rdata[CMD_STOP_BIT]  = cmd_stop_q;
        rdata[CMD_START_BIT] = cmd_start_q;
        rdata[CMD_RCMD_LSB+:2] = (state_q == RM_IDLE) ? 2'h0 :
                                 dir_wr_q ? RCMD_WRITE : RCMD_READ;
      end
      ISR_OFS:  rdata = {5'h00, isr_q};
      IMR_OFS:  rdata = {5'h00, imr_q};
      DCR_OFS:  rdata = dcr_q;
      TCR_OFS:  rdata = tcr_q;
      RSAR_OFS: rdata = rsar_q[7:0];
      RBCR_OFS: rdata = rbcr_q[7:0];
      STAT_OFS: begin
        rdata[STAT_BUSY]  = (state_q != RM_IDLE);
        rdata[STAT_RUN]   = mac_run;
        rdata[STAT_TXRST] = tx_domain_rst;
      end
      default:  rdata = 8'h00;
    endcase
  end

  // answer and read data, both registered
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= {24'h00_0000, rdata};
        // upper byte of 16-bit registers
        if (wb_adr_i == RSAR_OFS) begin
          wb_dat_o[15:8] <= rsar_q[15:8];
        end else if (wb_adr_i == RBCR_OFS) begin
          wb_dat_o[15:8] <= rbcr_q[15:8];
        end
      end
    end
  end

  // command: stop set and start clear after reset
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      cmd_stop_q  <= 1'b1;
      cmd_start_q <= 1'b0;
    end else if (wr_en && wb_adr_i == CMD_OFS) begin
      cmd_stop_q  <= wb_dat_i[CMD_STOP_BIT];
      cmd_start_q <= wb_dat_i[CMD_START_BIT];
    end
  end

  // remote command only starts from idle; busy writes are dropped
  assign launch_rd = wr_en && wb_adr_i == CMD_OFS &&
                     wb_dat_i[CMD_RCMD_LSB+:2] == RCMD_READ &&
                     state_q == RM_IDLE;
  assign launch_wr = wr_en && wb_adr_i == CMD_OFS &&
                     wb_dat_i[CMD_RCMD_LSB+:2] == RCMD_WRITE &&
                     state_q == RM_IDLE;

  // configuration registers
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      imr_q     <= IMR_RST;
      dcr_q     <= DCR_RST;
      tcr_q     <= TCR_RST;
      dcr_set_q <= 1'b0;
    end else if (wr_en) begin
      if (wb_adr_i == IMR_OFS) begin
        imr_q <= wb_dat_i[IRQ_W-1:0];
      end
      if (wb_adr_i == DCR_OFS) begin
        dcr_q     <= wb_dat_i[7:0];
        dcr_set_q <= 1'b1;
      end
      if (wb_adr_i == TCR_OFS) begin
        tcr_q <= wb_dat_i[7:0];
      end
    end
  end

  // address and count, byte lanes honoured; left alone by reset
  always_ff @(posedge clock) begin
    if (req && wb_we_i && wb_adr_i == RSAR_OFS) begin
      if (wb_sel_i[0]) rsar_q[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) rsar_q[15:8] <= wb_dat_i[15:8];
    end
    if (req && wb_we_i && wb_adr_i == RBCR_OFS) begin
      if (wb_sel_i[0]) rbcr_q[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) rbcr_q[15:8] <= wb_dat_i[15:8];
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign isr_set = {rdma_evt_q, tx_packet_done, rx_packet_done};
  assign isr_clr = (wr_en && wb_adr_i == ISR_OFS) ?
                   wb_dat_i[IRQ_W-1:0] : '0;

  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      isr_q <= ISR_RST;
    end else begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
    end
  end

  // one level output, only unmasked flags reach it
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      irq <= 1'b0;
    end else begin
      irq <= |(isr_q & imr_q);
    end
  end

  // mac may only run once started and not isolated
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      mac_run         <= 1'b0;
      line_encoder_decoder_test_mode <= 1'b0;
      loopback_mode   <= 2'h0;
    end else begin
      mac_run <= cmd_start_q & ~cmd_stop_q & sy[SY_ISO];
      line_encoder_decoder_test_mode <= ~sy[SY_ISO];
      loopback_mode   <= tcr_q[TCR_LOOP_LSB+:2];
    end
  end

  // idle pair level; equal when select high, else plus above
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      tx_pos <= 1'b0;
      tx_neg <= 1'b0;
    end else if (tx_active) begin
      tx_pos <= tx_enc_bit;
      tx_neg <= ~tx_enc_bit;
    end else begin
      tx_pos <= ~sy[SY_SEL];
      tx_neg <= 1'b0;
    end
  end

  // request pin driven only in 16-bit mode once configured
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      remote_transfer_request_oe <= 1'b0;
    end else begin
      remote_transfer_request_oe <= dcr_set_q & ~dcr_q[DCR_LAS_BIT];
    end
  end

  assign step = dcr_q[DCR_WTS_BIT] ? 16'h0002 : 16'h0001;

  // remote engine: request, acknowledge, then a t1..t4 cycle; the first read word goes straight to t1
  always_ff @(posedge clock or posedge rst_bus) begin
    if (rst_bus) begin
      state_q                 <= RM_IDLE;
      dir_wr_q                <= 1'b0;
      cnt_q                   <= 16'h0000;
      mem_addr                <= 16'h0000;
      mem_wdata               <= 16'h0000;
      mem_write               <= 1'b0;
      mem_read                <= 1'b0;
      port_data               <= 16'h0000;
      port_write              <= 1'b0;
      remote_transfer_request <= 1'b0;
      rdma_evt_q              <= 1'b0;
    end else begin
      port_write <= 1'b0;
      rdma_evt_q <= 1'b0;
      unique case (state_q)
        RM_IDLE: begin
          mem_addr <= rsar_q;
          cnt_q    <= rbcr_q;
          if ((launch_rd || launch_wr) && rbcr_q == 16'h0000) begin
            rdma_evt_q <= 1'b1;  // empty transfer ends at once
          end else if (launch_wr) begin
            dir_wr_q                <= 1'b1;
            remote_transfer_request <= 1'b1;
            state_q                 <= RM_REQ;
          end else if (launch_rd) begin
            dir_wr_q <= 1'b0;  // read fills the latch first
            state_q  <= RM_T1;
          end
        end
        RM_REQ: begin
          // host ack ends the request and opens a memory cycle
          if ((dir_wr_q && latch_write_ack_rise) ||
              (!dir_wr_q && latch_read_ack_rise)) begin
            remote_transfer_request <= 1'b0;
            state_q                 <= RM_T1;
          end
        end
        RM_T1: begin
          if (dir_wr_q) begin
            mem_wdata <= data_s[WORD_W-1:0];
          end
          state_q <= RM_T2;
        end
        RM_T2: begin
          mem_write <= dir_wr_q;
          mem_read  <= ~dir_wr_q;
          state_q   <= RM_T3;
        end
        RM_T3: begin
          // ready high inserts one wait clock at a time
          if (!sy[SY_RDY]) begin
            state_q <= RM_T4;
          end
        end
        RM_T4: begin
          mem_write <= 1'b0;
          mem_read  <= 1'b0;
          if (!dir_wr_q) begin
            port_data  <= data_s[2*WORD_W-1:WORD_W];
            port_write <= 1'b1;
          end
          mem_addr <= mem_addr + step;
          if (cnt_q <= step) begin
            cnt_q      <= 16'h0000;
            rdma_evt_q <= 1'b1;
            state_q    <= RM_IDLE;
          end else begin
            cnt_q                   <= cnt_q - step;
            remote_transfer_request <= 1'b1;
            state_q                 <= RM_REQ;
          end
        end
        default: state_q <= RM_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst_bus);

  sequence s_cycle_open;
    state_q == RM_T1 ##1 state_q == RM_T2;
  endsequence

  sequence s_latch_write_ack_taken;
    state_q == RM_REQ && dir_wr_q && latch_write_ack_rise;
  endsequence

  chk_not_started: assert property (
    !cmd_start_q |=> !mac_run)
    else $error("mac running without start bit");

  chk_reset_config: assert property (
    $fell(rst_bus) |-> imr_q == IMR_RST && dcr_q == DCR_RST &&
                       tcr_q == TCR_RST && cmd_stop_q && !cmd_start_q)
    else $error("config registers not reloaded by reset");

  chk_reset_bound: assert property (
    @(posedge clock) disable iff (1'b0)
    $fell(rst) |-> ##[1:9] !rst_bus)
    else $error("bus reset not released within ten clocks");

  chk_rx_event: assert property (
    rx_packet_done |=> isr_q[ISR_RX] ##1 irq || !imr_q[ISR_RX])
    else $error("receive event not latched");

  chk_clear_write: assert property (
    wr_en && wb_adr_i == ISR_OFS && wb_dat_i[ISR_TX] &&
    !tx_packet_done |=> !isr_q[ISR_TX])
    else $error("status write did not clear flag");

  chk_masked_quiet: assert property (
    (isr_q & imr_q) == 3'h0 |=> !irq)
    else $error("masked source drove interrupt");

  chk_irq_holds: assert property (
    |(isr_q & imr_q) |=> irq)
    else $error("interrupt low with unmasked flag");

  chk_latch_write_ack_write: assert property (
    s_latch_write_ack_taken |=> s_cycle_open ##1 mem_write)
    else $error("write ack did not start memory write");

  chk_request_start: assert property (
    launch_wr && rbcr_q != 16'h0000 |=> remote_transfer_request)
    else $error("remote write without request");

  chk_four_clocks: assert property (
    s_cycle_open ##1 (state_q == RM_T3 && !sy[SY_RDY])
    |=> state_q == RM_T4 ##1 !mem_write && !mem_read)
    else $error("memory cycle not four clocks");

  chk_idle_level: assert property (
    !tx_active && sy[SY_SEL] |=> !tx_pos && !tx_neg)
    else $error("idle pair not equal");

  chk_isolate: assert property (
    !sy[SY_ISO] |=> line_encoder_decoder_test_mode && !mac_run)
    else $error("isolation did not stop mac");

endmodule : hcrip_port

//--- src/hcrip_pkg.sv
// Operation
// - reset stops device until start bit set
// - reset reloads command, mask, data and transmit config
// - reset completes within ten bus and transmit cycles
// - interrupt on receive, transmit, remote transfer done
// - status register write clears pending interrupt
// - each interrupt source has its own mask
// - write ack starts a local memory write
// - idle level select shapes idle transmit pair
// - isolate input low exercises encoder alone
// - remote transfer request opens each 16-bit transfer except the first read word
// - memory cycle four clocks, ready stretches it
package hcrip_pkg;

  // bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CMD_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] ISR_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] IMR_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] DCR_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] TCR_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] RSAR_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RBCR_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h1C;

  // command fields
  localparam int CMD_STOP_BIT  = 0;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_RCMD_LSB  = 3;
  localparam logic [1:0] RCMD_READ  = 2'h1;
  localparam logic [1:0] RCMD_WRITE = 2'h2;

  // interrupt status and mask fields
  localparam int IRQ_W    = 3;
  localparam int ISR_RX   = 0;
  localparam int ISR_TX   = 1;
  localparam int ISR_RDMA = 2;

  // data and transmit configuration fields
  localparam int DCR_WTS_BIT  = 0;
  localparam int DCR_LAS_BIT  = 3;
  localparam int TCR_LOOP_LSB = 1;

  // status register fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_RUN   = 1;
  localparam int STAT_TXRST = 2;

  // reset values
  localparam logic [7:0]       DCR_RST = 8'h00;
  localparam logic [7:0]       TCR_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IMR_RST = 3'h0;
  localparam logic [IRQ_W-1:0] ISR_RST = 3'h0;

  // timing
  localparam int BUS_CLK_MHZ        = 100;
  localparam int RESET_LIMIT_CYCLES = 10;
  localparam logic [2:0] TX_RST_EDGES = 3'h2;

  // synchroniser lanes
  localparam int SY_TCLK = 0;
  localparam int SY_RDY  = 1;
  localparam int SY_LATCH_WRITE_ACK = 2;
  localparam int SY_LATCH_READ_ACK = 3;
  localparam int SY_SEL  = 4;
  localparam int SY_ISO  = 5;
  localparam int SY_W    = 6;
  localparam logic [SY_W-1:0] SY_RST = 6'h20;

  // remote transfer engine states
  typedef enum logic [2:0] {
    RM_IDLE = 3'h0,
    RM_REQ  = 3'h1,
    RM_T1   = 3'h2,
    RM_T2   = 3'h3,
    RM_T3   = 3'h4,
    RM_T4   = 3'h5
  } hcrip_rmt_e;

endpackage : hcrip_pkg

//--- src/hcrip_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser, the first stage feeds only the second
module hcrip_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;  // metastable stage, read by q only

  // both stages take a constant under reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : hcrip_sync

//--- test/hcrip_host_model.sv
`timescale 1ns/1ns
// host side of the latch: fills or empties it once per request
module hcrip_host_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        remote_transfer_request,
  input  wire logic        port_write,
  input  wire logic        mem_write,
  input  wire logic [15:0] mem_addr,
  output logic             latch_write_ack,
  output logic             latch_read_ack,
  output logic      [15:0] latch_data_in,
  output logic      [15:0] mem_rdata,
  output logic             mem_ready
);
  logic       busy_q; // ack sent, request not yet dropped
  logic       rd_q;   // a read word waits in the latch
  logic       mw_q;   // last mem_write, for edge detect
  logic [1:0] hold_q; // stall cycles spent on a write
  // memory answers with a pattern of its address
  assign mem_rdata = mem_addr ^ 16'h3C00;
  // one ack per request; even data words get a stalled write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {busy_q, rd_q, mw_q, hold_q, mem_ready} <= '0;
      {latch_write_ack, latch_read_ack} <= '0;
      latch_data_in <= 16'hA501;
    end else begin
      latch_write_ack <= 1'b0;
      latch_read_ack <= 1'b0;
      mw_q <= mem_write;
      // next word only once the device wrote the current one
      if (mem_write && !mw_q) latch_data_in <= latch_data_in + 16'h0001;
      if (port_write) rd_q <= 1'b1;
      if (!remote_transfer_request) busy_q <= 1'b0;
      else if (!busy_q) begin
        busy_q <= 1'b1;
        // a word handed over in this very cycle counts as waiting
        if (rd_q || port_write) begin
          latch_read_ack <= 1'b1;
          rd_q <= 1'b0;
        end else begin
          latch_write_ack <= 1'b1;
          mem_ready <= !latch_data_in[0];
        end
      end
      // release the wait after four stalled cycles
      if (mem_write && mem_ready) begin
        hold_q <= hold_q + 2'h1;
        if (hold_q == 2'h3) mem_ready <= 1'b0;
      end
    end
  end
endmodule : hcrip_host_model

//--- test/host_control_reset_irq_port_bench.sv
`timescale 1ns/1ns
// bench for the host control, reset and interrupt port
module host_control_reset_irq_port_bench;
  import hcrip_pkg::*;
  logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic        rx_packet_done, tx_packet_done, mac_run, transmit_clock;
  logic [1:0]  loopback_mode;
  logic        tx_domain_rst, remote_transfer_request, rq_oe, mem_ready;
  logic        latch_write_ack, latch_read_ack, mem_write, port_write;
  logic [15:0] latch_data_in, mem_rdata, mem_addr, mem_wdata, port_data;
  logic        idle_level_sel, tx_active, tx_enc_bit, tx_pos, tx_neg;
  logic        line_encoder_decoder_isolate_test_n, line_encoder_decoder_test_mode, rq_seen, mem_read;
  logic [15:0] wa[$], wd[$], pd_q[$]; // captured addresses and data
  int          error_cnt, n_tests, k, run, rd_n, wl[$];
  // rows: write flag, address, write data, expected read back
  localparam logic [27:0] ROWS [9] = '{
    28'h0_00_00_01, 28'h0_04_00_00, 28'h0_08_00_00, 28'h0_0C_00_00,
    28'h0_10_00_00, 28'h0_20_00_00, 28'h1_08_07_07, 28'h1_10_04_04,
    28'h1_20_55_00};

  hcrip_port dut_u (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .rx_packet_done(rx_packet_done),
    .tx_packet_done(tx_packet_done), .mac_run(mac_run),
    .loopback_mode(loopback_mode), .transmit_clock(transmit_clock),
    .tx_domain_rst(tx_domain_rst),
    .remote_transfer_request(remote_transfer_request),
    .remote_transfer_request_oe(rq_oe), .latch_write_ack(latch_write_ack),
    .latch_read_ack(latch_read_ack), .mem_ready(mem_ready),
    .latch_data_in(latch_data_in), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
    .mem_read(mem_read), .port_data(port_data), .port_write(port_write),
    .idle_level_sel(idle_level_sel), .tx_active(tx_active),
    .tx_enc_bit(tx_enc_bit), .tx_pos(tx_pos), .tx_neg(tx_neg),
    .line_encoder_decoder_isolate_test_n(line_encoder_decoder_isolate_test_n),
    .line_encoder_decoder_test_mode(line_encoder_decoder_test_mode));
  hcrip_host_model host_u (.clock(clock), .rst(rst),
    .remote_transfer_request(remote_transfer_request),
    .port_write(port_write), .mem_write(mem_write), .mem_addr(mem_addr),
    .latch_write_ack(latch_write_ack), .latch_read_ack(latch_read_ack),
    .latch_data_in(latch_data_in), .mem_rdata(mem_rdata),
    .mem_ready(mem_ready));

  // bus clock 100 MHz, transmit pin 25 MHz and unrelated in phase
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    transmit_clock = 1'b0;
    #3;
    forever #20 transmit_clock = ~transmit_clock;
  end
  // watchdog well beyond the expected run length
  initial begin
    #300000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
  // record strobes as seen at each edge, strobe length of each write
  always @(posedge clock) begin
    if (remote_transfer_request === 1'b1) rq_seen = 1'b1;
    if (port_write === 1'b1) pd_q.push_back(port_data);
    if (mem_read === 1'b1) rd_n++;
    if (mem_write === 1'b1) begin
      if (run == 0) wa.push_back(mem_addr);
      if (run == 0) wd.push_back(mem_wdata);
      run++;
    end else if (run != 0) begin
      wl.push_back(run);
      run = 0;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, s, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // one classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) @(posedge clock);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task run_rows(input int n);
    for (int i = 0; i < n; i++) begin
      if (ROWS[i][24]) wb(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      wb(1'b0, ROWS[i][23:16], 8'h00);
      chk(r, {24'h0, ROWS[i][7:0]}, "register row");
    end
  endtask : run_rows
  task wait_irq;
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clock);
  endtask : wait_irq
  // reset, checked while held and once it has run its course
  task do_reset;
    rst <= 1'b1;
    tick(2);
    chk(mac_run, 0, "run in reset");
    chk(irq, 0, "irq in reset");
    chk(tx_domain_rst, 1, "tx reset held");
    rst <= 1'b0;
    tick(40);
    chk(tx_domain_rst, 0, "tx reset late");
    $display("test reset done");
  endtask : do_reset
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, rx_packet_done, tx_packet_done} <= '0;
    {tx_active, tx_enc_bit, wb_adr_i, wb_dat_i} <= '0;
    {idle_level_sel, line_encoder_decoder_isolate_test_n, wb_sel_i} <= {2'b11, 4'hF};
    do_reset;
    run_rows(9);
    chk(loopback_mode, 2'b10, "loop mode");
    $display("test rows done");
    // masked source, then unmasked, cleared one flag at a time
    wb(1'b1, IMR_OFS, 8'h00);
    rx_packet_done <= 1'b1;
    tick(1);
    rx_packet_done <= 1'b0;
    tick(3);
    chk(irq, 0, "masked irq");
    wb(1'b0, ISR_OFS, 8'h00);
    chk(r, 1, "rx flag");
    wb(1'b1, IMR_OFS, 8'h03);
    tick(2);
    chk(irq, 1, "unmasked irq");
    tx_packet_done <= 1'b1;
    tick(1);
    tx_packet_done <= 1'b0;
    wb(1'b1, ISR_OFS, 8'h01);
    tick(2);
    chk(irq, 1, "one flag left");
    wb(1'b0, ISR_OFS, 8'h00);
    chk(r, 2, "tx flag kept");
    wb(1'b1, ISR_OFS, 8'h02);
    tick(2);
    chk(irq, 0, "all cleared");
    $display("test interrupts done");
    // two-word remote write, second word stalled by the host
    wb(1'b1, IMR_OFS, 8'h04);
    wb(1'b1, DCR_OFS, 8'h00);
    wb(1'b1, RSAR_OFS, 8'h40);
    wb(1'b1, RBCR_OFS, 8'h02);
    wb(1'b1, CMD_OFS, 8'h12);
    wait_irq;
    chk(irq, 1, "write done irq");
    chk({rq_oe, rq_seen}, 2'b11, "request out");
    chk(wa.size(), 2, "write count");
    for (int i = 0; i < 2; i++) begin
      chk(wa[i], 16'h0040 + i, "write addr");
      chk(wd[i], 16'hA501 + i, "write data");
    end
    chk(wl[0], 2, "plain cycle");
    chk(wl[1] > 2, 1, "stretched cycle");
    chk(mac_run, 1, "started");
    $display("test remote write done");
    // isolating the encoder stops the controller
    line_encoder_decoder_isolate_test_n <= 1'b0;
    tick(4);
    chk({line_encoder_decoder_test_mode, mac_run}, 2'b10, "isolated");
    line_encoder_decoder_isolate_test_n <= 1'b1;
    tick(4);
    chk({line_encoder_decoder_test_mode, mac_run}, 2'b01, "normal");
    $display("test isolate done");
    // two-word remote read, the second fetched after read ack
    wb(1'b1, ISR_OFS, 8'h04);
    tick(2);
    chk(irq, 0, "done cleared");
    wb(1'b1, RSAR_OFS, 8'h80);
    wb(1'b1, RBCR_OFS, 8'h02);
    wb(1'b1, CMD_OFS, 8'h0A);
    wait_irq;
    chk(pd_q.size(), 2, "read count");
    for (int i = 0; i < 2; i++) begin
      chk(pd_q[i], 16'h3C80 + i, "read data");
    end
    chk(rd_n, 4, "read strobes");
    chk(irq, 1, "read done irq");
    $display("test remote read done");
    // idle levels of the transmit pair for both selections
    for (int s = 0; s < 2; s++) begin
      idle_level_sel <= s[0];
      tick(4);
      if (s == 1) chk({tx_pos, tx_neg}, 2'b00, "equal idle");
      else chk({tx_pos, tx_neg}, 2'b10, "offset idle");
    end
    $display("test idle done");
    // reset in mid-run reloads the configuration
    do_reset;
    run_rows(6);
    end_sim;
  end
endmodule : host_control_reset_irq_port_bench
